// ### rtl/cspc_pkg.sv
// Purpose: constants for the clock source and prescaler control block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: How it works list follows
// How it works
// - fast internal oscillator runs 48 MHz when select is 0, 72 MHz when 1.
// - failure detector runs only when enabled and external oscillator ready.
// - bypass bit is writable only while external oscillator is off.
// - external ready flag follows stable external clock, else reads 0.
// - stop or standby entry clears the external oscillator enable.
// - clearing external enable is ignored while it feeds the core clock.
// - trim reads factory value; written trim applies only with source 0x1F.
// - trim source is write-only, reads 0; 1F picks software trim.
// - internal ready follows oscillator; falls six cycles after disable.
// - internal enable resets 1; forced 1 on wake and on failure while external feeds core.
// - clearing internal enable ignored while it feeds or is chosen as core.
// - configuration accesses get one or two waits during a source switch.
// - clock output select picks none, slow, core, fast/4 or external.
// - fast peripheral divider: 0xx undivided, 100..111 divide 2..16.
// - slow peripheral divider uses the same encoding.
// - main bus divider: 0xxx undivided, then 2,4,8,16,64,128,256,512.
// - switch status reports the active core clock source.
// - source select forced to internal on wake or on failure while external feeds core.
// - writing 1 to a clear bit clears its flag; clear bits read 0.
// - enable bits 11, 10, 8 gate the three ready interrupts.
// - failure flag set on detected failure, held until cleared.
// - external ready interrupt flag set on stable edge when enabled.
// - internal ready interrupt flag set on stable edge when enabled.
// - slow ready interrupt flag set on stable edge when enabled.
// - failure while external feeds core switches core to internal.
// - a requested source change takes effect only once the target is ready.
package cspc_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_IRQ = 8'h08;
  localparam int B_FREQ = 20;
  localparam int B_DET = 19;
  localparam int B_BYP = 18;
  localparam int B_XRDY = 17;
  localparam int B_XEN = 16;
  localparam int B_TRIM = 8;
  localparam int B_TSRC = 3;
  localparam int B_IRDY = 1;
  localparam int B_IEN = 0;
  localparam int B_MCO = 24;
  localparam int B_PFAST = 11;
  localparam int B_PSLOW = 8;
  localparam int B_MAIN = 4;
  localparam int B_SWS = 2;
  localparam int B_FCLR = 23;
  localparam int B_XCLR = 19;
  localparam int B_ICLR = 18;
  localparam int B_SCLR = 16;
  localparam int B_XIE = 11;
  localparam int B_IIE = 10;
  localparam int B_SIE = 8;
  localparam int B_FFLG = 7;
  localparam int B_XFLG = 3;
  localparam int B_IFLG = 2;
  localparam int B_SFLG = 0;
  localparam logic [7:0] TRIM_RST = 8'hFF;
  localparam logic [4:0] TSRC_SW = 5'h1F;
  localparam logic [2:0] IRDY_FALL_CYC = 3'h6;
  localparam logic [1:0] SWITCH_WAIT = 2'h2;
  typedef enum logic [1:0] {
    CSPC_SRC_DIV6 = 2'b00,
    CSPC_SRC_EXT = 2'b01,
    CSPC_SRC_INT = 2'b10,
    CSPC_SRC_SLOW = 2'b11
  } cspc_src_t;
  typedef enum logic [2:0] {
    CSPC_OUT_NONE = 3'b000,
    CSPC_OUT_SLOW = 3'b010,
    CSPC_OUT_CORE = 3'b100,
    CSPC_OUT_INT4 = 3'b101,
    CSPC_OUT_EXT = 3'b110
  } cspc_out_t;
endpackage

// ### rtl/cspc_top.sv
// Purpose: clock source, trim, failure detector and prescaler control
// Assumes: oscillator status pins are asynchronous to clk_sys_in
// Notes: divider outputs are ratio codes for the clock tree, not clocks
`timescale 1ns/100ps
module cspc_top
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic wb_we_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [7:0] factory_trim_in,
  input wire logic ext_stable_in,
  input wire logic int_stable_in,
  input wire logic slow_stable_in,
  input wire logic ext_fail_in,
  input wire logic low_power_in,
  output logic ext_osc_enable_out,
  output logic ext_osc_bypass_out,
  output logic int_osc_enable_out,
  output logic fast_int_freq_select_out,
  output logic [7:0] int_osc_trim_out,
  output logic failure_detector_on_out,
  output logic [1:0] core_src_out,
  output logic [2:0] clock_output_select_out,
  output logic [9:0] main_div_out,
  output logic [4:0] fast_periph_div_out,
  output logic [4:0] slow_periph_div_out,
  output logic clk_irq_out,
  output logic failure_irq_out
);
  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [2:0] rdy_d_r;
  logic lp_d_r;
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end
    else
    begin
      sync1_r <= {low_power_in, ext_fail_in, slow_stable_in,
                  int_stable_in, ext_stable_in};
      sync2_r <= sync1_r;
    end
  end
  logic ext_st;
  logic int_st;
  logic slow_st;
  logic fail_st;
  logic lp_st;
  assign ext_st = sync2_r[0];
  assign int_st = sync2_r[1];
  assign slow_st = sync2_r[2];
  assign fail_st = sync2_r[3];
  assign lp_st = sync2_r[4];

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic xen_r;
  logic byp_r;
  logic det_r;
  logic freq_r;
  logic ien_r;
  logic [7:0] trim_r;
  logic soft_trim_r;
  logic xrdy_r;
  logic irdy_r;
  logic [2:0] ifall_r;
  logic [2:0] mco_r;
  logic [2:0] pfast_r;
  logic [2:0] pslow_r;
  logic [3:0] main_r;
  logic [1:0] sw_r;
  logic [1:0] sws_r;
  logic [1:0] wait_r;
  logic xie_r;
  logic iie_r;
  logic sie_r;
  logic fflg_r;
  logic xflg_r;
  logic iflg_r;
  logic sflg_r;
  logic failure;
  logic wake;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_irq;
  logic [31:0] wd;
  logic ext_core;
  logic int_core;
  logic [1:0] pend;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic src_ready(input logic [1:0] s,
                                     input logic x, input logic i,
                                     input logic l);
    case (s)
      2'b01: src_ready = x;
      2'b11: src_ready = l;
      default: src_ready = i;
    endcase
  endfunction

  function automatic logic [4:0] pdiv(input logic [2:0] c);
    pdiv = c[2] ? 5'h02 << c[1:0] : 5'h01;
  endfunction

  function automatic logic [9:0] mdiv(input logic [3:0] c);
    case (c[3:2])
      2'b10: mdiv = 10'h002 << c[1:0];
      2'b11: mdiv = 10'h040 << c[1:0];
      default: mdiv = 10'h001;
    endcase
  endfunction

  assign wd = wb_dat_in & lane_mask(wb_sel_in);
  assign wr_ctrl = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out
                   && wb_adr_in == cspc_pkg::ADDR_CTRL;
  assign wr_cfg = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out
                  && wait_r == 2'h0 && wb_adr_in == cspc_pkg::ADDR_CFG;
  assign wr_irq = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out
                  && wb_adr_in == cspc_pkg::ADDR_IRQ;
  assign ext_core = sws_r == cspc_pkg::CSPC_SRC_EXT;
  assign int_core = sws_r == cspc_pkg::CSPC_SRC_DIV6 ||
                    sws_r == cspc_pkg::CSPC_SRC_INT;
  assign failure = fail_st && det_r && xrdy_r;
  assign wake = lp_d_r && !lp_st;
  assign pend = wr_cfg && wb_sel_in[0] ? wb_dat_in[1:0] : sw_r;

  // external oscillator control
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      xen_r <= 1'b0;
      byp_r <= 1'b0;
      det_r <= 1'b0;
      freq_r <= 1'b0;
    end
    else
    begin
      if (lp_st || (failure && ext_core))
        xen_r <= 1'b0;
      else if (wr_ctrl && wb_sel_in[2])
        xen_r <= wd[cspc_pkg::B_XEN] | (xen_r & ext_core);
      if (wr_ctrl && wb_sel_in[2] && !xen_r)
        byp_r <= wd[cspc_pkg::B_BYP];
      if (wr_ctrl && wb_sel_in[2])
      begin
        det_r <= wd[cspc_pkg::B_DET];
        freq_r <= wd[cspc_pkg::B_FREQ];
      end
    end
  end

  // internal oscillator control and trim
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      ien_r <= 1'b1;
      trim_r <= cspc_pkg::TRIM_RST;
      soft_trim_r <= 1'b0;
    end
    else
    begin
      if (wake || (failure && ext_core))
        ien_r <= 1'b1;
      else if (wr_ctrl && wb_sel_in[0])
        ien_r <= wd[cspc_pkg::B_IEN] | int_core |
                 (pend != cspc_pkg::CSPC_SRC_EXT &&
                  pend != cspc_pkg::CSPC_SRC_SLOW);
      if (wr_ctrl && wb_sel_in[0])
        soft_trim_r <= wd[7:3] == cspc_pkg::TSRC_SW;
      if (wr_ctrl && wb_sel_in[1] && wb_sel_in[0] &&
          wd[7:3] == cspc_pkg::TSRC_SW)
        trim_r <= wd[15:8];
    end
  end

  // ready flags
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      xrdy_r <= 1'b0;
      irdy_r <= 1'b0;
      ifall_r <= 3'h0;
      rdy_d_r <= 3'h0;
      lp_d_r <= 1'b0;
    end
    else
    begin
      xrdy_r <= xen_r && ext_st;
      rdy_d_r <= {slow_st, irdy_r, xrdy_r};
      lp_d_r <= lp_st;
      if (ien_r)
      begin
        ifall_r <= 3'h0;
        irdy_r <= int_st;
      end
      else if (irdy_r)
      begin
        if (ifall_r == cspc_pkg::IRDY_FALL_CYC - 3'h1)
          irdy_r <= 1'b0;
        ifall_r <= ifall_r + 3'h1;
      end
    end
  end

  // configuration register and source switch
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      mco_r <= 3'h0;
      pfast_r <= 3'h0;
      pslow_r <= 3'h0;
      main_r <= 4'h0;
      sw_r <= 2'h0;
      sws_r <= 2'h0;
      wait_r <= 2'h0;
    end
    else
    begin
      if (wr_cfg && wb_sel_in[3])
        mco_r <= wd[cspc_pkg::B_MCO +: 3];
      if (wr_cfg && wb_sel_in[1])
      begin
        pfast_r <= wd[cspc_pkg::B_PFAST +: 3];
        pslow_r <= wd[cspc_pkg::B_PSLOW +: 3];
      end
      if (wr_cfg && wb_sel_in[0])
        main_r <= wd[cspc_pkg::B_MAIN +: 4];
      if (wake || (failure && ext_core))
        sw_r <= cspc_pkg::CSPC_SRC_INT;
      else if (wr_cfg && wb_sel_in[0])
        sw_r <= wd[1:0];
      if (wait_r != 2'h0)
        wait_r <= wait_r - 2'h1;
      if ((failure && ext_core) || wake)
      begin
        sws_r <= cspc_pkg::CSPC_SRC_INT;
        wait_r <= cspc_pkg::SWITCH_WAIT;
      end
      else if (sw_r != sws_r &&
               src_ready(sw_r, xrdy_r, irdy_r, slow_st))
      begin
        sws_r <= sw_r;
        wait_r <= cspc_pkg::SWITCH_WAIT;
      end
    end
  end

  // interrupt register
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      xie_r <= 1'b0;
      iie_r <= 1'b0;
      sie_r <= 1'b0;
      fflg_r <= 1'b0;
      xflg_r <= 1'b0;
      iflg_r <= 1'b0;
      sflg_r <= 1'b0;
    end
    else
    begin
      if (wr_irq && wb_sel_in[1])
      begin
        xie_r <= wd[cspc_pkg::B_XIE];
        iie_r <= wd[cspc_pkg::B_IIE];
        sie_r <= wd[cspc_pkg::B_SIE];
      end
      if (failure)
        fflg_r <= 1'b1;
      else if (wr_irq && wd[cspc_pkg::B_FCLR])
        fflg_r <= 1'b0;
      if (xie_r && xrdy_r && !rdy_d_r[0])
        xflg_r <= 1'b1;
      else if (wr_irq && wd[cspc_pkg::B_XCLR])
        xflg_r <= 1'b0;
      if (iie_r && irdy_r && !rdy_d_r[1])
        iflg_r <= 1'b1;
      else if (wr_irq && wd[cspc_pkg::B_ICLR])
        iflg_r <= 1'b0;
      if (sie_r && slow_st && !rdy_d_r[2])
        sflg_r <= 1'b1;
      else if (wr_irq && wd[cspc_pkg::B_SCLR])
        sflg_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave and outputs
  logic [31:0] rd;
  always_comb
  begin
    rd = 32'h0000_0000;
    case (wb_adr_in)
      cspc_pkg::ADDR_CTRL:
        rd = {11'h000, freq_r, det_r, byp_r, xrdy_r, xen_r,
              factory_trim_in, 5'h00, 1'b0, irdy_r, ien_r};
      cspc_pkg::ADDR_CFG:
        rd = {5'h00, mco_r, 10'h000, pfast_r, pslow_r, main_r,
              sws_r, sw_r};
      cspc_pkg::ADDR_IRQ:
        rd = {20'h00000, xie_r, iie_r, 1'b0, sie_r, fflg_r, 3'h0,
              xflg_r, iflg_r, 1'b0, sflg_r};
      default: rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out &&
                    !(wb_adr_in == cspc_pkg::ADDR_CFG &&
                      wait_r != 2'h0);
      wb_dat_out <= rd;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      ext_osc_enable_out <= 1'b0;
      ext_osc_bypass_out <= 1'b0;
      int_osc_enable_out <= 1'b1;
      fast_int_freq_select_out <= 1'b0;
      int_osc_trim_out <= cspc_pkg::TRIM_RST;
      failure_detector_on_out <= 1'b0;
      core_src_out <= 2'h0;
      clock_output_select_out <= 3'h0;
      main_div_out <= 10'h001;
      fast_periph_div_out <= 5'h01;
      slow_periph_div_out <= 5'h01;
      clk_irq_out <= 1'b0;
      failure_irq_out <= 1'b0;
    end
    else
    begin
      ext_osc_enable_out <= xen_r;
      ext_osc_bypass_out <= byp_r;
      int_osc_enable_out <= ien_r;
      fast_int_freq_select_out <= freq_r;
      int_osc_trim_out <= soft_trim_r ? trim_r : factory_trim_in;
      failure_detector_on_out <= det_r && xrdy_r;
      core_src_out <= sws_r;
      clock_output_select_out <= (mco_r == 3'b011 || mco_r == 3'b111 ||
                                  mco_r[2:1] == 2'b00) ?
                                 cspc_pkg::CSPC_OUT_NONE : mco_r;
      main_div_out <= mdiv(main_r);
      fast_periph_div_out <= pdiv(pfast_r);
      slow_periph_div_out <= pdiv(pslow_r);
      clk_irq_out <= xflg_r || iflg_r || sflg_r;
      failure_irq_out <= fflg_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  ext_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    ext_core && xen_r && !lp_st && !failure |=> xen_r)
    else $error("external enable dropped while feeding core");
  byp_lock_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    xen_r && $past(xen_r) |-> $stable(byp_r))
    else $error("bypass changed while oscillator on");
  irq_any_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (xflg_r || iflg_r || sflg_r) |=> clk_irq_out)
    else $error("clock interrupt missing");
  fail_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fflg_r && !(wr_irq && wd[cspc_pkg::B_FCLR]) |=> fflg_r)
    else $error("failure flag lost");
  src_switch_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    sws_r != $past(sws_r) && !$past(wake) && !$past(failure) |->
    $past(src_ready(sw_r, xrdy_r, irdy_r, slow_st)))
    else $error("switched to unready source");
  irdy_fall_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !ien_r && irdy_r && ifall_r == 3'h0 ##1 !ien_r[*5] |=> !irdy_r)
    else $error("internal ready did not fall in six cycles");
  cfg_wait_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wait_r != 2'h0 && wb_adr_in == cspc_pkg::ADDR_CFG |=> !wb_ack_out)
    else $error("configuration acked during switch");
  wake_force_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wake |=> ien_r && sw_r == cspc_pkg::CSPC_SRC_INT)
    else $error("wake did not force internal source");
  stop_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    lp_st |=> !xen_r)
    else $error("external enable kept in low power");
endmodule // cspc_top

// ### tb/cspc_top_test.sv
// Purpose: self-checking bench for the clock source and prescaler block
// Assumes: classic wishbone, ack waited for under a bounded count
// Notes: oscillator status pins are driven directly by the bench
`timescale 1ns/100ps
module cspc_top_test;
  logic clk_sys_in;
  logic rst_n_in;
  logic [7:0] wb_adr_in;
  logic [31:0] wb_dat_in;
  logic [3:0] wb_sel_in;
  logic wb_we_in;
  logic wb_cyc_in;
  logic wb_stb_in;
  logic [31:0] wb_dat_out;
  logic wb_ack_out;
  logic [7:0] factory_trim_in;
  logic ext_stable_in;
  logic int_stable_in;
  logic slow_stable_in;
  logic ext_fail_in;
  logic low_power_in;
  logic ext_osc_enable_out;
  logic ext_osc_bypass_out;
  logic int_osc_enable_out;
  logic fast_int_freq_select_out;
  logic [7:0] int_osc_trim_out;
  logic failure_detector_on_out;
  logic [1:0] core_src_out;
  logic [2:0] clock_output_select_out;
  logic [9:0] main_div_out;
  logic [4:0] fast_periph_div_out;
  logic [4:0] slow_periph_div_out;
  logic clk_irq_out;
  logic failure_irq_out;
  int fails;
  int compares;
  ////////////////////////////////////////////////////////////////////
  cspc_top u_dut
  (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in), .wb_sel_in(wb_sel_in),
    .wb_we_in(wb_we_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .factory_trim_in(factory_trim_in), .ext_stable_in(ext_stable_in),
    .int_stable_in(int_stable_in), .slow_stable_in(slow_stable_in),
    .ext_fail_in(ext_fail_in), .low_power_in(low_power_in),
    .ext_osc_enable_out(ext_osc_enable_out),
    .ext_osc_bypass_out(ext_osc_bypass_out),
    .int_osc_enable_out(int_osc_enable_out),
    .fast_int_freq_select_out(fast_int_freq_select_out),
    .int_osc_trim_out(int_osc_trim_out),
    .failure_detector_on_out(failure_detector_on_out),
    .core_src_out(core_src_out),
    .clock_output_select_out(clock_output_select_out),
    .main_div_out(main_div_out), .fast_periph_div_out(fast_periph_div_out),
    .slow_periph_div_out(slow_periph_div_out),
    .clk_irq_out(clk_irq_out), .failure_irq_out(failure_irq_out)
  );
  ////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_sys_in);
    wb_adr_in <= a;
    wb_we_in <= w;
    wb_dat_in <= d;
    wb_sel_in <= 4'hF;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (wb_ack_out !== 1'b1 && n < 20);
    r = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
    if (wb_ack_out !== 1'b1)
    begin
      fails++;
      $display("wrong value ack expected 1 seen %b", wb_ack_out);
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(a, 1'b1, d, r);
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    wb(a, 1'b0, 32'h0, r);
    chk(nm, e, r & m);
  endtask
  function automatic logic [9:0] main_ratio(input int c);
    if (c < 8)
      return 10'h001;
    return (c < 12) ? 10'(1 << (c - 7)) : 10'(1 << (c - 6));
  endfunction
  function automatic logic [4:0] per_ratio(input int c);
    return (c < 4) ? 5'h01 : 5'(1 << (c - 3));
  endfunction
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    fails = 0;
    compares = 0;
    rst_n_in = 1'b0;
    {wb_adr_in, wb_dat_in, wb_sel_in} = '0;
    {wb_we_in, wb_cyc_in, wb_stb_in} = '0;
    factory_trim_in = 8'hA5;
    {ext_stable_in, slow_stable_in, ext_fail_in, low_power_in} = '0;
    int_stable_in = 1'b1;
    tick(3);
    rst_n_in <= 1'b1;
    tick(4);
    rd("ctrl reset", 8'h00, 32'hFFFFFFFF, 32'h0000A503);
    rd("cfg reset", 8'h04, 32'hFFFFFFFF, 32'h00000000);
    wr(8'h0C, 32'hFFFFFFFF);
    rd("unmapped", 8'h0C, 32'hFFFFFFFF, 32'h00000000);
    wr(8'h08, 32'hFFFFFFFF);
    rd("irq enables", 8'h08, 32'hFFFFFFFF, 32'h00000D00);
    // ready edges while enabled
    slow_stable_in <= 1'b1;
    int_stable_in <= 1'b0;
    tick(8);
    int_stable_in <= 1'b1;
    tick(6);
    rd("irq flags", 8'h08, 32'hFFFFFFFF, 32'h00000D05);
    chk("clk irq", 32'h1, 32'(clk_irq_out));
    wr(8'h00, 32'h001D0001);
    // pins follow the register state one edge after the write lands
    tick(1);
    chk("freq sel", 32'h1, 32'(fast_int_freq_select_out));
    chk("bypass", 32'h1, 32'(ext_osc_bypass_out));
    chk("det off", 32'h0, 32'(failure_detector_on_out));
    wr(8'h00, 32'h00190001);
    rd("bypass held", 8'h00, 32'hFFFFFFFF, 32'h001DA503);
    ext_stable_in <= 1'b1;
    tick(6);
    rd("ext ready", 8'h00, 32'h00020000, 32'h00020000);
    chk("det on", 32'h1, 32'(failure_detector_on_out));
    rd("ext flag", 8'h08, 32'hFFFFFFFF, 32'h00000D0D);
    wr(8'h08, 32'h00000D00);
    rd("zero clear", 8'h08, 32'hFFFFFFFF, 32'h00000D0D);
    wr(8'h08, 32'h000D0D00);
    rd("cleared", 8'h08, 32'hFFFFFFFF, 32'h00000D00);
    chk("clk irq off", 32'h0, 32'(clk_irq_out));
    wr(8'h08, 32'h00000000);
    slow_stable_in <= 1'b0;
    tick(6);
    slow_stable_in <= 1'b1;
    tick(6);
    rd("masked", 8'h08, 32'hFFFFFFFF, 32'h00000000);
    wr(8'h00, 32'h001D3CF9);
    rd("trim read", 8'h00, 32'h0000FFF8, 32'h0000A500);
    chk("sw trim", 32'h3C, 32'(int_osc_trim_out));
    wr(8'h00, 32'h001D7701);
    tick(1);
    chk("factory trim", 32'hA5, 32'(int_osc_trim_out));
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h04, {5'h0, 3'(i), 10'h0, 3'(i), ~3'(i), 4'(i), 4'h0});
      tick(2);
      chk("main div", 32'(main_ratio(i)), 32'(main_div_out));
      chk("fast div", 32'(per_ratio(i % 8)), 32'(fast_periph_div_out));
      chk("slow div", 32'(per_ratio(7 - i % 8)), 32'(slow_periph_div_out));
      chk("clk out", (i % 8 inside {2, 4, 5, 6}) ? 32'(i % 8) : 32'h0,
          32'(clock_output_select_out));
      rd("cfg fields", 8'h04, 32'h00003FF0,
         {18'h0, 3'(i), ~3'(i), 4'(i), 4'h0});
    end
    wr(8'h04, 32'h00000001);
    rd("during switch", 8'h04, 32'h00000001, 32'h00000001);
    tick(6);
    chk("core ext", 32'h1, 32'(core_src_out));
    rd("status ext", 8'h04, 32'h0000000F, 32'h00000005);
    wr(8'h00, 32'h00180001);
    tick(1);
    chk("ext kept", 32'h1, 32'(ext_osc_enable_out));
    ext_fail_in <= 1'b1;
    tick(6);
    ext_fail_in <= 1'b0;
    chk("core to int", 32'h2, 32'(core_src_out));
    chk("ext off", 32'h0, 32'(ext_osc_enable_out));
    chk("int forced", 32'h1, 32'(int_osc_enable_out));
    chk("fail irq", 32'h1, 32'(failure_irq_out));
    rd("sel forced", 8'h04, 32'h0000000F, 32'h0000000A);
    rd("fail flag", 8'h08, 32'h00000080, 32'h00000080);
    wr(8'h08, 32'h00800000);
    tick(1);
    chk("fail cleared", 32'h0, 32'(failure_irq_out));
    ext_stable_in <= 1'b0;
    tick(4);
    wr(8'h04, 32'h00000001);
    tick(10);
    chk("no switch", 32'h2, 32'(core_src_out));
    wr(8'h04, 32'h00000002);
    tick(4);
    wr(8'h00, 32'h00100000);
    tick(1);
    chk("int kept", 32'h1, 32'(int_osc_enable_out));
    wr(8'h04, 32'h00000003);
    tick(6);
    chk("core slow", 32'h3, 32'(core_src_out));
    wr(8'h00, 32'h00100000);
    tick(1);
    chk("int off", 32'h0, 32'(int_osc_enable_out));
    rd("int ready held", 8'h00, 32'h00000003, 32'h00000002);
    tick(10);
    rd("int ready fell", 8'h00, 32'h00000003, 32'h00000000);
    wr(8'h00, 32'h00110000);
    tick(1);
    chk("ext on", 32'h1, 32'(ext_osc_enable_out));
    low_power_in <= 1'b1;
    tick(5);
    chk("stop ext", 32'h0, 32'(ext_osc_enable_out));
    low_power_in <= 1'b0;
    tick(12);
    chk("wake int", 32'h1, 32'(int_osc_enable_out));
    rd("wake sel", 8'h04, 32'h00000003, 32'h00000002);
    conclude();
  end
endmodule // cspc_top_test
